// >>> hdl/tmr_core.sv
// Timer top: AXI4-Lite registers, clock select, counter, compare and flags
// Behaviour
// [R1] Force A applies compare to output A
// [R2] Force B applies compare to output B
// [R3] Forced compare sets no flag, no clear
// [R4] Force bits always read back zero
// [R5] Control B bit 3 is mode MSB
// [R6] Select 000 stops; 001-101 divide I/O clock
// [R7] Select 110 falling, 111 rising pin edges
// [R8] Pin edges count even when pin driven
// [R9] Counter read/write; write blocks next match
// [R10] Compare A matched against counter continuously
// [R11] Compare B matched against counter continuously
// [R12] Request needs enable, global bit, flag
// [R13] Match B flag: set, vector or W1C clears
// [R14] Match A flag: set, vector or W1C clears
// [R15] Overflow flag: set, vector or W1C clears
// [R16] Overflow point depends on waveform mode
// [R17] Overflow at MAX, BOTTOM, or TOP per mode
// [R18] Non-PWM output modes: off, toggle, clear, set
// [R19] Pin synchronised, edge detected before counting
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tmr_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ext_count_pin,
  input  wire logic [2:0]  vector_ack,
  output logic             wave_out_a,
  output logic             wave_out_a_en,
  output logic             wave_out_b,
  output logic             wave_out_b_en,
  output logic [2:0]       irq_req,
  output logic             irq
);

  tmr_pkg::tmr_core_s st_q;
  tmr_pkg::tmr_core_s st_d;

  logic       presc_tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       tick;
  logic [2:0] mode;
  logic [7:0] top;
  logic       is_pwm;
  logic       is_phase;
  logic       match_a;
  logic       match_b;
  logic       ovf;
  logic       wrap;
  logic       wr_go;
  logic       wr_hit;
  logic       cnt_wr;
  logic       force_a;
  logic       force_b;
  logic [2:0] set_fl;
  logic [2:0] clr_fl;
  logic [7:0] rd_val;
  logic       rd_hit;

  tmr_prescale #(.CNT_W(tmr_pkg::PRESC_W)) u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sel     (st_q.clock_source_select),
    .tick    (presc_tick)
  );

  // The pin is sampled as an input whatever drives it
  tmr_pin_edge u_pin (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (ext_count_pin), // R8
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:10] == 2'h0) && (a[9:2] == idx);
  endfunction : hit

  // Next level of one waveform output after a match or a wrap
  function automatic logic wave_next(input logic cur, input logic [1:0] om, input logic m,
                                     input logic wr, input logic pwm, input logic phase,
                                     input logic down, input logic tog_ok);
    logic v;
    v = cur;
    if (!pwm) begin
      if (m) begin
        case (om) // R18
          tmr_pkg::OM_TOGGLE: v = ~cur;
          tmr_pkg::OM_CLEAR:  v = 1'b0;
          tmr_pkg::OM_SET:    v = 1'b1;
          default:            v = cur;
        endcase
      end
    end else if (om == tmr_pkg::OM_TOGGLE) begin
      if (m && tog_ok) begin
        v = ~cur;
      end
    end else if (om != tmr_pkg::OM_OFF) begin
      if (phase) begin
        if (m) begin
          v = (om == tmr_pkg::OM_SET) ^ down;
        end
      end else begin
        if (m) begin
          v = (om == tmr_pkg::OM_SET);
        end
        // Bottom wins, which also covers the compare-equals-top case
        if (wr) begin
          v = (om == tmr_pkg::OM_CLEAR);
        end
      end
    end
    wave_next = v;
  endfunction : wave_next

  always_comb begin
    st_d = st_q;
    mode = {st_q.wave_mode_msb, st_q.wave_mode_low_bits}; // R5
    is_pwm = st_q.wave_mode_low_bits[0];
    is_phase = (mode == tmr_pkg::MODE_PC_FF) || (mode == tmr_pkg::MODE_PC_OCA);
    top = tmr_pkg::BYTE_MAX;
    if ((mode == tmr_pkg::MODE_CLR_MATCH) || (mode == tmr_pkg::MODE_PC_OCA)
        || (mode == tmr_pkg::MODE_FAST_OCA)) begin
      top = st_q.cmp_a;
    end

    case (st_q.clock_source_select)
      tmr_pkg::CS_STOP:     tick = 1'b0; // R6
      tmr_pkg::CS_EXT_FALL: tick = pin_fall; // R7 R19
      tmr_pkg::CS_EXT_RISE: tick = pin_rise; // R7 R19
      default:              tick = presc_tick; // R6
    endcase

    match_a = tick && (st_q.count == st_q.cmp_a) && !st_q.block_match; // R10 R9
    match_b = tick && (st_q.count == st_q.cmp_b) && !st_q.block_match; // R11 R9
    wrap = tick && !is_phase && (st_q.count == top);

    // R16 R17
    if (is_phase) begin
      ovf = tick && st_q.dir_down && (st_q.count == tmr_pkg::BOTTOM);
    end else if (mode == tmr_pkg::MODE_FAST_OCA) begin
      ovf = tick && (st_q.count == top);
    end else begin
      ovf = tick && (st_q.count == tmr_pkg::BYTE_MAX);
    end

    if (tick) begin
      st_d.block_match = 1'b0;
      if (is_phase) begin
        if (!st_q.dir_down && (st_q.count == top)) begin
          st_d.dir_down = 1'b1;
          st_d.count = st_q.count - 1'b1;
        end else if (st_q.dir_down && (st_q.count == tmr_pkg::BOTTOM)) begin
          st_d.dir_down = 1'b0;
          st_d.count = st_q.count + 1'b1;
        end else begin
          st_d.count = st_q.dir_down ? st_q.count - 1'b1 : st_q.count + 1'b1;
        end
      end else begin
        st_d.dir_down = 1'b0;
        st_d.count = wrap ? tmr_pkg::BOTTOM : st_q.count + 1'b1;
      end
    end

    // Write channel: both halves captured, then executed in one cycle
    awready = !st_q.aw_have && !st_q.b_valid;
    wready = !st_q.w_have && !st_q.b_valid;
    if (awvalid && awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_d.w_have = 1'b1;
      st_d.w_data = wdata[7:0];
      st_d.w_lane0 = wstrb[0];
    end
    wr_go = st_q.aw_have && st_q.w_have && !st_q.b_valid;
    wr_hit = hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_A) || hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_B)
           || hit(st_q.aw_addr, tmr_pkg::IDX_COUNT) || hit(st_q.aw_addr, tmr_pkg::IDX_CMP_A)
           || hit(st_q.aw_addr, tmr_pkg::IDX_CMP_B) || hit(st_q.aw_addr, tmr_pkg::IDX_MASK)
           || hit(st_q.aw_addr, tmr_pkg::IDX_FLAGS) || hit(st_q.aw_addr, tmr_pkg::IDX_GLOBAL);
    cnt_wr = wr_go && st_q.w_lane0 && hit(st_q.aw_addr, tmr_pkg::IDX_COUNT);
    // Strobes only take effect outside PWM modes; they are never stored
    force_a = wr_go && st_q.w_lane0 && hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_B)
            && st_q.w_data[tmr_pkg::BIT_FORCE_A] && !is_pwm; // R1
    force_b = wr_go && st_q.w_lane0 && hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_B)
            && st_q.w_data[tmr_pkg::BIT_FORCE_B] && !is_pwm; // R2
    clr_fl = vector_ack;
    if (wr_go) begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.b_valid = 1'b1;
      st_d.b_resp = wr_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      if (st_q.w_lane0) begin
        if (hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_A)) begin
          st_d.out_mode_a = st_q.w_data[tmr_pkg::OUT_A_LSB +: 2];
          st_d.out_mode_b = st_q.w_data[tmr_pkg::OUT_B_LSB +: 2];
          st_d.wave_mode_low_bits = st_q.w_data[1:0];
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_CTRL_B)) begin
          st_d.wave_mode_msb = st_q.w_data[tmr_pkg::BIT_WAVE_MSB]; // R5
          st_d.clock_source_select = st_q.w_data[2:0];
        end
        if (cnt_wr) begin
          st_d.count = st_q.w_data; // R9
          st_d.block_match = 1'b1; // R9
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_CMP_A)) begin
          st_d.cmp_a = st_q.w_data;
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_CMP_B)) begin
          st_d.cmp_b = st_q.w_data;
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_MASK)) begin
          st_d.mask = st_q.w_data[2:0]; // R12
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_FLAGS)) begin
          clr_fl = vector_ack | st_q.w_data[2:0]; // R13 R14 R15
        end
        if (hit(st_q.aw_addr, tmr_pkg::IDX_GLOBAL)) begin
          st_d.global_en = st_q.w_data[tmr_pkg::BIT_GLOBAL];
        end
      end
    end
    if (st_q.b_valid && bready) begin
      st_d.b_valid = 1'b0;
    end

    // Forced strobes reach only the outputs: no flag, no counter clear
    set_fl = '0;
    set_fl[tmr_pkg::FLAG_B] = match_b; // R13 R3
    set_fl[tmr_pkg::FLAG_A] = match_a; // R14 R3
    set_fl[tmr_pkg::FLAG_OVF] = ovf; // R15
    // A flag set in the same cycle as its clear stays set
    st_d.flags = (st_q.flags & ~clr_fl) | set_fl;

    st_d.out_a = wave_next(st_q.out_a, st_q.out_mode_a, match_a || force_a, wrap, is_pwm, is_phase,
                           st_q.dir_down, st_q.wave_mode_msb); // R1 R10
    st_d.out_b = wave_next(st_q.out_b, st_q.out_mode_b, match_b || force_b, wrap, is_pwm, is_phase,
                           st_q.dir_down, 1'b0); // R2 R11

    // Read channel
    arready = !st_q.r_valid;
    rd_hit = 1'b1;
    if (hit(araddr, tmr_pkg::IDX_CTRL_A)) begin
      rd_val = {st_q.out_mode_a, st_q.out_mode_b, 2'h0, st_q.wave_mode_low_bits};
    end else if (hit(araddr, tmr_pkg::IDX_CTRL_B)) begin
      rd_val = {4'h0, st_q.wave_mode_msb, st_q.clock_source_select}; // R4
    end else if (hit(araddr, tmr_pkg::IDX_COUNT)) begin
      rd_val = st_q.count;
    end else if (hit(araddr, tmr_pkg::IDX_CMP_A)) begin
      rd_val = st_q.cmp_a;
    end else if (hit(araddr, tmr_pkg::IDX_CMP_B)) begin
      rd_val = st_q.cmp_b;
    end else if (hit(araddr, tmr_pkg::IDX_MASK)) begin
      rd_val = {5'h00, st_q.mask};
    end else if (hit(araddr, tmr_pkg::IDX_FLAGS)) begin
      rd_val = {5'h00, st_q.flags};
    end else if (hit(araddr, tmr_pkg::IDX_GLOBAL)) begin
      rd_val = {7'h00, st_q.global_en};
    end else begin
      rd_val = tmr_pkg::RST_BYTE;
      rd_hit = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.r_valid = 1'b1;
      st_d.r_data = rd_val;
      st_d.r_resp = rd_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end else if (st_q.r_valid && rready) begin
      st_d.r_valid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bvalid = st_q.b_valid;
  assign bresp = st_q.b_resp;
  assign rvalid = st_q.r_valid;
  assign rresp = st_q.r_resp;
  assign rdata = {24'h000000, st_q.r_data};
  assign wave_out_a = st_q.out_a;
  assign wave_out_b = st_q.out_b;
  assign wave_out_a_en = st_q.out_mode_a != tmr_pkg::OM_OFF;
  assign wave_out_b_en = st_q.out_mode_b != tmr_pkg::OM_OFF;
  assign irq_req = st_q.flags & st_q.mask & {3{st_q.global_en}}; // R12
  assign irq = |irq_req;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_force_a_set: assert property (force_a && st_q.out_mode_a == tmr_pkg::OM_SET |=> wave_out_a) // R1
    else $error("forced compare A did not set the output");
  chk_force_b_clear: assert property (force_b && st_q.out_mode_b == tmr_pkg::OM_CLEAR |=> !wave_out_b) // R2
    else $error("forced compare B did not clear the output");
  chk_force_no_flag: assert property (force_a && !tick && !st_q.flags[tmr_pkg::FLAG_A]
                                      |=> !st_q.flags[tmr_pkg::FLAG_A]) // R3
    else $error("forced compare raised a flag");
  chk_force_reads_zero: assert property (arvalid && arready && hit(araddr, tmr_pkg::IDX_CTRL_B)
                                         |=> rvalid && rdata[7:6] == 2'b00) // R4
    else $error("force bits read back non-zero");
  chk_stop_holds: assert property (st_q.clock_source_select == tmr_pkg::CS_STOP && !cnt_wr
                                   |=> st_q.count == $past(st_q.count)) // R6
    else $error("stopped counter moved");
  chk_div8_spacing: assert property (tick && st_q.clock_source_select == tmr_pkg::CS_DIV8
                                     |=> (!tick || st_q.clock_source_select != tmr_pkg::CS_DIV8)[*7]) // R6
    else $error("divide-by-8 ticks too close");
  chk_write_blocks: assert property (cnt_wr |=> !match_a && !match_b) // R9
    else $error("match taken right after a counter write");
  chk_irq_gate: assert property (!st_q.global_en |-> !irq) // R12
    else $error("interrupt raised with global enable clear");
  chk_ovf_normal: assert property (mode == tmr_pkg::MODE_NORMAL && tick && st_q.count == tmr_pkg::BYTE_MAX && !cnt_wr
                                   |=> st_q.count == tmr_pkg::BOTTOM && st_q.flags[tmr_pkg::FLAG_OVF]) // R17
    else $error("normal mode overflow not flagged at MAX");
  chk_flag_set_wins: assert property (match_b |=> st_q.flags[tmr_pkg::FLAG_B]) // R13
    else $error("compare B match lost");

  cov_force_a: cover property (force_a ##1 wave_out_a_en);
  cov_ext_tick: cover property (st_q.clock_source_select == tmr_pkg::CS_EXT_RISE && tick);
  cov_overflow: cover property (ovf ##1 irq);
  cov_ack_clear: cover property (vector_ack[tmr_pkg::FLAG_A] && st_q.flags[tmr_pkg::FLAG_A]);

endmodule : tmr_core

// >>> hdl/tmr_pkg.sv
// Shared constants, register map and state structs for the 8-bit timer block
package tmr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PRESC_W = 10;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'h30;
  localparam logic [7:0] IDX_CTRL_B = 8'h25;
  localparam logic [7:0] IDX_COUNT = 8'h31;
  localparam logic [7:0] IDX_CMP_A = 8'h32;
  localparam logic [7:0] IDX_CMP_B = 8'h28;
  localparam logic [7:0] IDX_MASK = 8'h6E;
  localparam logic [7:0] IDX_FLAGS = 8'h33;
  localparam logic [7:0] IDX_GLOBAL = 8'h34;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BOTTOM = 8'h00;

  // Field positions
  localparam int unsigned BIT_FORCE_A = 7;
  localparam int unsigned BIT_FORCE_B = 6;
  localparam int unsigned BIT_WAVE_MSB = 3;
  localparam int unsigned OUT_A_LSB = 6;
  localparam int unsigned OUT_B_LSB = 4;
  localparam int unsigned FLAG_B = 2;
  localparam int unsigned FLAG_A = 1;
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned BIT_GLOBAL = 0;

  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler masks: a tick whenever the masked low bits are all zero
  localparam logic [PRESC_W-1:0] MASK_8 = 10'h007;
  localparam logic [PRESC_W-1:0] MASK_64 = 10'h03F;
  localparam logic [PRESC_W-1:0] MASK_256 = 10'h0FF;
  localparam logic [PRESC_W-1:0] MASK_1024 = 10'h3FF;

  // Waveform generation modes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_OCA = 3'h5;
  localparam logic [2:0] MODE_FAST_OCA = 3'h7;

  // Compare output modes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [PRESC_W-1:0] cnt;
  } tmr_presc_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } tmr_sync_s;

  typedef struct packed {
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              b_valid;
    logic [1:0]        b_resp;
    logic              r_valid;
    logic [7:0]        r_data;
    logic [1:0]        r_resp;
    logic [1:0]        out_mode_a;
    logic [1:0]        out_mode_b;
    logic [1:0]        wave_mode_low_bits;
    logic              wave_mode_msb;
    logic [2:0]        clock_source_select;
    logic [7:0]        count;
    logic [7:0]        cmp_a;
    logic [7:0]        cmp_b;
    logic [2:0]        mask;
    logic [2:0]        flags;
    logic              global_en;
    logic              dir_down;
    logic              block_match;
    logic              out_a;
    logic              out_b;
  } tmr_core_s;

endpackage : tmr_pkg

// >>> hdl/tmr_prescale.sv
// Free-running prescaler giving a one-cycle tick at the selected division
`timescale 1ns/10ps
module tmr_prescale #(
  parameter int unsigned CNT_W = 10
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] sel,
  output logic            tick
);

  if (CNT_W != tmr_pkg::PRESC_W) begin : g_chk
    $error("tmr_prescale: CNT_W must equal the prescaler width");
  end

  tmr_pkg::tmr_presc_s st_q;
  tmr_pkg::tmr_presc_s st_d;
  logic [CNT_W-1:0]    msk;

  always_comb begin
    st_d = st_q;
    st_d.cnt = st_q.cnt + 1'b1;
    case (sel)
      tmr_pkg::CS_DIV8:    msk = tmr_pkg::MASK_8;
      tmr_pkg::CS_DIV64:   msk = tmr_pkg::MASK_64;
      tmr_pkg::CS_DIV256:  msk = tmr_pkg::MASK_256;
      tmr_pkg::CS_DIV1024: msk = tmr_pkg::MASK_1024;
      default:             msk = '0;
    endcase
    tick = (st_q.cnt & msk) == '0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : tmr_prescale

// >>> hdl/tmr_pin_edge.sv
// Three-stage synchroniser and edge detector for the external count pin
`timescale 1ns/10ps
module tmr_pin_edge (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  tmr_pkg::tmr_sync_s st_q;
  tmr_pkg::tmr_sync_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A level only counts once the last two stages agree
    if (st_q.s2 == st_q.s3) begin
      st_d.level = st_q.s3;
    end
    rise = st_d.level & ~st_q.level;
    fall = ~st_d.level & st_q.level;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : tmr_pin_edge

// >>> verif/tmr_pin_model.sv
// Behavioural source driving a burst of pulses onto the external count pin
`timescale 1ns/10ps
module tmr_pin_model #(
  parameter int unsigned PULSES = 5
) (
  input  wire logic aclk,
  input  wire logic go,
  output logic      busy,
  output logic      ext_count_pin
);
  // Sixteen cycles per pulse keep each level well past the synchroniser depth
  // Start-up values sit on the declarations so each register has one driving process
  logic [3:0] ph_q   = 4'h0;
  logic [7:0] left_q = 8'h00;
  logic       pin_q  = 1'b0;
  assign ext_count_pin = pin_q;
  assign busy = (left_q != 8'h00);
  always @(posedge aclk) begin
    if (go && !busy) begin
      left_q <= PULSES[7:0];
      ph_q <= 4'h0;
    end else if (busy) begin
      ph_q <= ph_q + 4'h1;
      if (ph_q == 4'h7) pin_q <= 1'b1;
      if (ph_q == 4'hF) begin
        pin_q <= 1'b0;
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule : tmr_pin_model

// >>> verif/tmr_core_tb_top.sv
// Self-checking bench for the timer core through its AXI4-Lite registers
`timescale 1ns/10ps
module tmr_core_tb_top;
  localparam logic [11:0] A_CA = {2'b00, tmr_pkg::IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_CB = {2'b00, tmr_pkg::IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_CN = {2'b00, tmr_pkg::IDX_COUNT, 2'b00};
  localparam logic [11:0] A_OA = {2'b00, tmr_pkg::IDX_CMP_A, 2'b00};
  localparam logic [11:0] A_OB = {2'b00, tmr_pkg::IDX_CMP_B, 2'b00};
  localparam logic [11:0] A_MK = {2'b00, tmr_pkg::IDX_MASK, 2'b00};
  localparam logic [11:0] A_FL = {2'b00, tmr_pkg::IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_GL = {2'b00, tmr_pkg::IDX_GLOBAL, 2'b00};
  localparam logic [11:0] A_BAD = 12'h7FC;
  localparam logic [1:0] FM [4] = '{tmr_pkg::OM_SET, tmr_pkg::OM_TOGGLE, tmr_pkg::OM_CLEAR, tmr_pkg::OM_TOGGLE};
  localparam int DIV [6] = '{1, 1, 8, 64, 256, 1024};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, pin, busy;
  logic        awready, wready, bvalid, arready, rvalid, wa, wa_en, wb, wb_en, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp;
  logic [2:0]  vector_ack, irq_req;
  logic [7:0]  rd_byte;
  int          err_total, samples_checked, i, n;

  tmr_core dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_count_pin(pin), .vector_ack(vector_ack),
    .wave_out_a(wa), .wave_out_a_en(wa_en), .wave_out_b(wb), .wave_out_b_en(wb_en),
    .irq_req(irq_req), .irq(irq));
  tmr_pin_model #(.PULSES(5)) partner (.aclk(aclk), .go(go), .busy(busy), .ext_count_pin(pin));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic fail(input string m);
    err_total++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) fail($sformatf("byte %h expected %h", g, e));
  endtask : cmp8
  task automatic cmp1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) fail($sformatf("pin %b expected %b", g, e));
  endtask : cmp1
  task automatic cmp_rng(input logic [7:0] g, input int lo, input int hi);
    samples_checked++;
    if ((^g === 1'bx) || int'(g) < lo || int'(g) > hi) fail($sformatf("count %h outside %0d..%0d", g, lo, hi));
  endtask : cmp_rng
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task automatic timeout();
    fail("bounded wait ran out");
    report_and_stop();
  endtask : timeout
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note

  // Response ready is held high throughout so no strobe is lowered and raised in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int k;
    tb = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50 && !tb; k++) begin
      @(negedge aclk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = (bvalid === 1'b1);
      last_resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!tb) timeout();
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic tr, tv;
    int k;
    tv = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50 && !tv; k++) begin
      @(negedge aclk);
      tr = arvalid && (arready === 1'b1);
      tv = (rvalid === 1'b1);
      rd_byte = rdata[7:0];
      last_resp = rresp;
      @(posedge aclk);
      if (tr) arvalid <= 1'b0;
    end
    if (!tv) timeout();
  endtask : rd
  task automatic chk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    cmp8(rd_byte, e);
  endtask : chk
  task automatic vec(input logic [2:0] v);
    vector_ack <= v;
    @(posedge aclk);
    vector_ack <= 3'h0;
  endtask : vec

  initial begin
    {aresetn, awvalid, wvalid, arvalid, go} = 5'h00;
    {bready, rready} = 2'b11;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    vector_ack = 3'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(A_CB, 8'h00);
    chk(A_OB, 8'h00);
    chk(A_MK, 8'h00);
    rd(A_BAD);
    cmp8({6'h0, last_resp}, {6'h0, tmr_pkg::RESP_SLVERR});
    wr(A_BAD, 8'h55);
    cmp8({6'h0, last_resp}, {6'h0, tmr_pkg::RESP_SLVERR});
    note("reset");
    // Counter stays stopped so only the strobes can move the outputs
    for (i = 0; i < 4; i++) begin
      wr(A_CA, {FM[i], FM[i], 4'h0});
      wr(A_CB, 8'hC0);
      cmp1(wa, i == 1 || i == 2 ? 1'b0 : 1'b1);
      cmp1(wb, i == 1 || i == 2 ? 1'b0 : 1'b1);
      cmp1(wa_en, 1'b1);
    end
    wr(A_CA, 8'h00);
    wr(A_CB, 8'hC0);
    cmp1(wb_en, 1'b0);
    chk(A_CB, 8'h00);
    chk(A_FL, 8'h00);
    wr(A_CB, 8'h08);
    chk(A_CB, 8'h08);
    note("force");
    // Prescaler phase is free running, so each window allows up to six extra ticks
    for (i = 0; i < 6; i++) begin
      wr(A_CB, 8'h00);
      wr(A_CN, 8'h00);
      wr(A_CB, i[7:0]);
      repeat (10 * DIV[i]) @(posedge aclk);
      wr(A_CB, 8'h00);
      rd(A_CN);
      cmp_rng(rd_byte, i == 0 ? 0 : 10, i == 0 ? 0 : 16);
    end
    for (i = 6; i < 8; i++) begin
      wr(A_CN, 8'h00);
      wr(A_CB, i[7:0]);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      @(posedge aclk);
      for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge aclk);
      if (busy !== 1'b0) timeout();
      repeat (8) @(posedge aclk);
      wr(A_CB, 8'h00);
      chk(A_CN, 8'h05);
    end
    note("clock select");
    wr(A_CN, 8'h5A);
    chk(A_CN, 8'h5A);
    wr(A_OA, 8'h20);
    wr(A_OB, 8'h60);
    wr(A_CN, 8'h20);
    wr(A_FL, 8'h07);
    wr(A_CB, 8'h01);
    repeat (3) @(posedge aclk);
    wr(A_CB, 8'h00);
    chk(A_FL, 8'h00);
    wr(A_OA, 8'hF4);
    wr(A_OB, 8'hF2);
    wr(A_CN, 8'hF0);
    wr(A_CB, 8'h01);
    repeat (20) @(posedge aclk);
    wr(A_CB, 8'h00);
    chk(A_OA, 8'hF4);
    chk(A_OB, 8'hF2);
    chk(A_FL, 8'h07);
    note("match and overflow");
    wr(A_MK, 8'h07);
    chk(A_MK, 8'h07);
    cmp1(irq, 1'b0);
    wr(A_GL, 8'h01);
    cmp8({5'h0, irq_req}, 8'h07);
    cmp1(irq, 1'b1);
    wr(A_FL, 8'h00);
    chk(A_FL, 8'h07);
    wr(A_FL, 8'h02);
    chk(A_FL, 8'h05);
    wr(A_MK, 8'h02);
    cmp1(irq, 1'b0);
    vec(3'h4);
    chk(A_FL, 8'h01);
    vec(3'h1);
    chk(A_FL, 8'h00);
    note("interrupts");
    // Clear-on-match with top 0x10: only match A, the count never reaches 0xFF
    wr(A_FL, 8'h07);
    wr(A_OA, 8'h10);
    wr(A_CN, 8'h00);
    wr(A_CA, 8'h02);
    wr(A_CB, 8'h01);
    repeat (40) @(posedge aclk);
    wr(A_CB, 8'h00);
    chk(A_FL, 8'h02);
    rd(A_CN);
    cmp_rng(rd_byte, 0, 16);
    // Fast PWM with compare A as top: overflow flags at top, not at 0xFF
    wr(A_FL, 8'h07);
    wr(A_CN, 8'h00);
    wr(A_CA, 8'h03);
    wr(A_CB, 8'h09);
    repeat (40) @(posedge aclk);
    wr(A_CB, 8'h08);
    chk(A_FL, 8'h03);
    cmp1(irq, 1'b1);
    wr(A_CA, 8'h83);
    wr(A_CB, 8'h88);
    cmp1(wa, 1'b1);
    note("modes");
    report_and_stop();
  end
endmodule : tmr_core_tb_top
